// *** logic/spse_core.sv ***
// Serial port control register with collision, overflow and enable bits.
//
// Function
// - In I2C host modes a buffer write on a busy bus sets collision.
// - In client modes a write during shifting sets a sticky collision.
// - In SPI modes a byte arriving at an unread buffer sets overflow.
// - The enable bit in SPI modes hands the four SPI pins to the port.
// - The enable bit in I2C modes hands the SDA and SCL pins to the port.
// - Clearing the enable bit returns the pins to general I/O use.
`timescale 1ns/1ps
`include "spse_defines.svh"
module spse_core #(
    // Bus widths; only the documented widths are served.
    parameter int ADDR_WIDTH = 5,
    parameter int DATA_WIDTH = 32
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AXI4-Lite slave.
    input wire logic [ADDR_WIDTH-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [DATA_WIDTH-1:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output spse_pkg::spse_resp_type bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [ADDR_WIDTH-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [DATA_WIDTH-1:0] rdata_o,
    output spse_pkg::spse_resp_type rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // Shift engine side.
    input wire logic shift_busy_i,
    input wire logic bus_idle_i,
    input wire logic rx_done_i,
    input wire spse_pkg::spse_byte_type rx_byte_i,
    output spse_pkg::spse_byte_type tx_byte_o,
    output logic tx_load_o,
    output logic [3:0] port_mode_o,
    // Pin ownership.
    output logic port_enable_o,
    output logic spi_pins_own_o,
    output logic i2c_pins_own_o,
    // Interrupt.
    output logic irq_o
);
    import spse_pkg::*;

    // The register map and read mux are laid out for these widths only.
    if (ADDR_WIDTH != 5 || DATA_WIDTH != 32) begin : g_width_check
        $error("spse_core serves only 5-bit addresses and 32-bit data");
    end

    // Register state.
    spse_byte_type ctrl;
    spse_byte_type shift_buffer;
    logic buf_full;
    logic [1:0] stat;
    logic [1:0] mask;
    // Write channel holding registers and decoded strobes.
    logic aw_got, w_got;
    logic [4:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go, rd_go;
    logic buf_wr, buf_rd;
    logic wr_ctrl, wr_stat, wr_mask;
    logic buf_take;
    // Event flags and mode family.
    logic write_collision_flag, receive_overflow_flag;
    logic set_write_collision_flag, set_rov;
    logic is_i2c, is_host_i2c, is_client;
    logic [3:0] mode;

    // True when the write completing this cycle lands in the given word.
    function automatic logic wr_hit(input logic go, input logic [3:0] strb,
                                    input logic [4:0] a, input logic [4:0] t);
        wr_hit = go && strb[0] && (a == t);
    endfunction

    function automatic logic addr_ok(input logic [4:0] a);
        addr_ok = (a == `SPSE_ADDR_CTRL) || (a == `SPSE_ADDR_BUF) ||
                  (a == `SPSE_ADDR_STAT) || (a == `SPSE_ADDR_MASK);
    endfunction

    assign mode = ctrl[`SPSE_MODE_HI:`SPSE_MODE_LO];
    assign is_i2c = mode >= `SPSE_MODE_I2C_MIN;
    assign is_host_i2c = (mode == `SPSE_MODE_I2C_HOST_A) ||
                         (mode == `SPSE_MODE_I2C_HOST_FW);
    assign is_client = !is_host_i2c &&
                       ((mode == `SPSE_MODE_SPI_CLIENT_A) ||
                        (mode == `SPSE_MODE_SPI_CLIENT_B) || is_i2c);

    // Write channel capture; address and data may come in either order.
    // Both stall while a response waits, so one write is in flight.
    assign awready_o = !aw_got && !bvalid_o;
    assign wready_o = !w_got && !bvalid_o;
    assign wr_go = aw_got && w_got && !bvalid_o;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 5'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (awvalid_i && awready_o) begin
                aw_got <= 1'b1;
                aw_addr <= awaddr_i;
            end else if (wr_go) begin
                aw_got <= 1'b0;
            end
            if (wvalid_i && wready_o) begin
                w_got <= 1'b1;
                w_data <= wdata_i;
                w_strb <= wstrb_i;
            end else if (wr_go) begin
                w_got <= 1'b0;
            end
        end
    end

    // The response stands until the master takes it.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bvalid_o <= 1'b0;
            bresp_o <= `SPSE_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_o <= 1'b1;
            bresp_o <= addr_ok(aw_addr) ? `SPSE_RESP_OKAY : `SPSE_RESP_SLVERR;
        end else if (bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    // Decoded register writes; a clear low byte lane leaves the word alone.
    assign wr_ctrl = wr_hit(wr_go, w_strb, aw_addr, `SPSE_ADDR_CTRL);
    assign wr_stat = wr_hit(wr_go, w_strb, aw_addr, `SPSE_ADDR_STAT);
    assign wr_mask = wr_hit(wr_go, w_strb, aw_addr, `SPSE_ADDR_MASK);
    assign buf_wr = wr_hit(wr_go, w_strb, aw_addr, `SPSE_ADDR_BUF);

    // Control register; flags live in their own processes below.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl <= `SPSE_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= w_data[7:0];
        end
    end

    // A buffer write starts a transfer only when the moment is legal.
    assign set_write_collision_flag = buf_wr && ctrl[`SPSE_BIT_EN] &&
        ((is_host_i2c && !bus_idle_i) ||
         (is_client && shift_busy_i));
    assign set_rov = rx_done_i && !is_i2c && buf_full &&
        ctrl[`SPSE_BIT_EN];
    // A collided write is dropped so the byte on the wire is not corrupted.
    assign buf_take = buf_wr && !set_write_collision_flag;

    // Set wins over a software clear in the same cycle, so no event is lost.
    // Writing a zero clears a flag; writing a one leaves it as it is.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            write_collision_flag <= 1'b0;
        end else if (set_write_collision_flag) begin
            write_collision_flag <= 1'b1;
        end else if (wr_ctrl && !w_data[`SPSE_BIT_WRITE_COLLISION_FLAG]) begin
            write_collision_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            receive_overflow_flag <= 1'b0;
        end else if (set_rov) begin
            receive_overflow_flag <= 1'b1;
        end else if (wr_ctrl && !w_data[`SPSE_BIT_ROV]) begin
            receive_overflow_flag <= 1'b0;
        end
    end

    // Shift buffer: on overflow in SPI the old unread byte is kept.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shift_buffer <= 8'h00;
        end else if (rx_done_i && !(buf_full && !is_i2c)) begin
            shift_buffer <= rx_byte_i;
        end else if (buf_take) begin
            shift_buffer <= w_data[7:0];
        end
    end

    // Every reception marks the buffer full, so transfers go on regardless.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            buf_full <= 1'b0;
        end else if (rx_done_i) begin
            buf_full <= 1'b1;
        end else if (buf_rd) begin
            buf_full <= 1'b0;
        end
    end

    // A disabled port starts nothing, though the written byte is kept.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_load_o <= 1'b0;
        end else begin
            tx_load_o <= buf_take && ctrl[`SPSE_BIT_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_byte_o <= 8'h00;
        end else if (buf_take) begin
            tx_byte_o <= w_data[7:0];
        end
    end

    // Interrupt status: write one to clear, set wins.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stat <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0) ? set_write_collision_flag : set_rov) begin
                    stat[i] <= 1'b1;
                end else if (wr_stat && w_data[i]) begin
                    stat[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mask <= 2'b00;
        end else if (wr_mask) begin
            mask <= w_data[1:0];
        end
    end

    // Level interrupt: any pending event whose mask bit is set.
    assign irq_o = |(stat & mask);

    // Read channel; unmapped words answer with an error and read as zero.
    // Reading the buffer word frees it for the next reception.
    assign arready_o = !rvalid_o;
    assign rd_go = arvalid_i && arready_o;
    assign buf_rd = rd_go && araddr_i == `SPSE_ADDR_BUF;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            rresp_o <= `SPSE_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_o <= 1'b1;
            rresp_o <= addr_ok(araddr_i) ? `SPSE_RESP_OKAY :
                       `SPSE_RESP_SLVERR;
            case (araddr_i)
                `SPSE_ADDR_CTRL: begin
                    rdata_o <= {24'h000000, write_collision_flag,
                                receive_overflow_flag,
                                ctrl[`SPSE_BIT_EN:`SPSE_MODE_LO]};
                end
                `SPSE_ADDR_BUF: begin
                    rdata_o <= {24'h000000, shift_buffer};
                end
                `SPSE_ADDR_STAT: begin
                    rdata_o <= {30'h0, stat};
                end
                `SPSE_ADDR_MASK: begin
                    rdata_o <= {30'h0, mask};
                end
                default: begin
                    rdata_o <= 32'h0000_0000;
                end
            endcase
        end else if (rready_i) begin
            rvalid_o <= 1'b0;
        end
    end

    // Pin ownership follows the enable bit and the mode family.
    // Reserved mode codes still pick a pin family by their value.
    assign port_mode_o = mode;
    assign port_enable_o = ctrl[`SPSE_BIT_EN];
    assign spi_pins_own_o = ctrl[`SPSE_BIT_EN] && !is_i2c;
    assign i2c_pins_own_o = ctrl[`SPSE_BIT_EN] && is_i2c;
endmodule

// *** logic/spse_defines.svh ***
// Register offsets, bit positions, reset values and mode codes.
`ifndef SPSE_DEFINES_SVH
`define SPSE_DEFINES_SVH
`define SPSE_ADDR_CTRL 5'h00
`define SPSE_ADDR_BUF 5'h04
`define SPSE_ADDR_STAT 5'h08
`define SPSE_ADDR_MASK 5'h0c
`define SPSE_BIT_WRITE_COLLISION_FLAG 7
`define SPSE_BIT_ROV 6
`define SPSE_BIT_EN 5
`define SPSE_MODE_LO 0
`define SPSE_MODE_HI 3
`define SPSE_MODE_I2C_MIN 4'h6
`define SPSE_MODE_SPI_CLIENT_A 4'h4
`define SPSE_MODE_SPI_CLIENT_B 4'h5
`define SPSE_MODE_I2C_HOST_FW 4'hb
`define SPSE_MODE_I2C_HOST_A 4'h8
`define SPSE_CTRL_RESET 8'h00
`define SPSE_RESP_OKAY 2'b00
`define SPSE_RESP_SLVERR 2'b10
`endif

// *** logic/spse_pkg.sv ***
// Types shared by the serial port status and enable block.
package spse_pkg;
    typedef logic [7:0] spse_byte_type;
    typedef logic [1:0] spse_resp_type;
endpackage

// *** tb/spse_checker.sv ***
// Checker for the pin ownership, load and bus handshake outputs.
`timescale 1ns/1ps
module spse_checker (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bus handshakes.
    input wire logic awready_o,
    input wire logic bvalid_o,
    input wire logic arvalid_i,
    input wire logic arready_o,
    input wire logic rvalid_o,
    // Port state.
    input wire logic [3:0] port_mode_o,
    input wire logic port_enable_o,
    input wire logic spi_pins_own_o,
    input wire logic i2c_pins_own_o,
    input wire logic tx_load_o,
    // Shift engine conditions.
    input wire logic shift_busy_i,
    input wire logic bus_idle_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ar_take;
        arvalid_i && arready_o;
    endsequence
    chk_spi_pin_own: assert property (
        spi_pins_own_o == (port_enable_o && port_mode_o < 4'h6))
        else $error("spi pin ownership wrong");
    chk_i2c_pin_own: assert property (
        i2c_pins_own_o == (port_enable_o && port_mode_o >= 4'h6))
        else $error("i2c pin ownership wrong");
    chk_pins_released: assert property (
        !port_enable_o |-> !spi_pins_own_o && !i2c_pins_own_o)
        else $error("pins kept while disabled");
    chk_load_with_resp: assert property (
        tx_load_o |-> bvalid_o) else $error("load without write");
    chk_load_pulse: assert property (
        tx_load_o |=> !tx_load_o) else $error("load not a pulse");
    sequence s_client_load;
        tx_load_o && (port_mode_o == 4'h4 || port_mode_o == 4'h5);
    endsequence
    sequence s_host_load;
        tx_load_o && (port_mode_o == 4'h8 || port_mode_o == 4'hb);
    endsequence
    chk_client_not_busy: assert property (
        s_client_load |-> !$past(shift_busy_i))
        else $error("load started while shifting");
    chk_host_bus_idle: assert property (
        s_host_load |-> $past(bus_idle_i))
        else $error("load started on a busy bus");
    chk_load_enabled: assert property (
        tx_load_o |-> port_enable_o)
        else $error("load started while disabled");
    chk_read_answer: assert property (s_ar_take |=> rvalid_o)
        else $error("read not answered");
    chk_ar_blocked: assert property (rvalid_o |-> !arready_o)
        else $error("read taken while busy");
    chk_aw_blocked: assert property (bvalid_o |-> !awready_o)
        else $error("write taken while busy");
endmodule
bind spse_core spse_checker chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .awready_o(awready_o), .bvalid_o(bvalid_o), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rvalid_o(rvalid_o), .port_mode_o(port_mode_o),
    .port_enable_o(port_enable_o), .spi_pins_own_o(spi_pins_own_o),
    .i2c_pins_own_o(i2c_pins_own_o), .tx_load_o(tx_load_o),
    .shift_busy_i(shift_busy_i), .bus_idle_i(bus_idle_i));

// *** tb/spse_peer.sv ***
// Far side model that hands received bytes to the block.
`timescale 1ns/1ps
module spse_peer (
    // Clock.
    input wire logic clk_i,
    // Receive side.
    output logic rx_done_o,
    output spse_pkg::spse_byte_type rx_byte_o
);
    import spse_pkg::*;
    initial begin
        rx_done_o = 1'b0;
        rx_byte_o = 8'h00;
    end
    // Data goes stale after the pulse, so it is inverted then.
    task rx(input spse_byte_type b);
        @(posedge clk_i);
        rx_done_o <= 1'b1;
        rx_byte_o <= b;
        @(posedge clk_i);
        rx_done_o <= 1'b0;
        rx_byte_o <= ~b;
    endtask
endmodule

// *** tb/serial_port_status_enable_bits_tb.sv ***
// Self-checking bench for the serial port status and enable block.
`timescale 1ns/1ps
`include "spse_defines.svh"
module serial_port_status_enable_bits_tb;
    import spse_pkg::*;
    logic clk_i, rst_n_i, awv, wv, brdy, arv, rrdy, busy, idle, rxd;
    logic awr, wr_r, bv, arr, rv, ld, en, so, io, irq;
    logic [4:0] awa, ara;
    logic [31:0] wd, rdat, rd;
    logic [3:0] mode, strb;
    spse_resp_type br, rr, rsp;
    spse_byte_type txb, rxb;
    int err_total, comparisons, loads;
    spse_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .awaddr_i(awa),
        .awvalid_i(awv), .awready_o(awr), .wdata_i(wd), .wstrb_i(strb),
        .wvalid_i(wv), .wready_o(wr_r), .bresp_o(br), .bvalid_o(bv),
        .bready_i(brdy), .araddr_i(ara), .arvalid_i(arv), .arready_o(arr),
        .rdata_o(rdat), .rresp_o(rr), .rvalid_o(rv), .rready_i(rrdy),
        .shift_busy_i(busy), .bus_idle_i(idle), .rx_done_i(rxd),
        .rx_byte_i(rxb), .tx_byte_o(txb), .tx_load_o(ld),
        .port_mode_o(mode), .port_enable_o(en), .spi_pins_own_o(so),
        .i2c_pins_own_o(io), .irq_o(irq));
    spse_peer peer (.clk_i(clk_i), .rx_done_o(rxd), .rx_byte_o(rxb));
    always @(negedge clk_i) if (ld === 1'b1) loads++;
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task end_sim;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv && n < 40);
        brdy <= 1'b0;
        if (n >= 40) begin
            err_total++;
            end_sim;
        end
    endtask
    task rdr(input logic [4:0] a);
        int n;
        n = 0;
        @(posedge clk_i);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 40);
        rd = rdat;
        rsp = rr;
        rrdy <= 1'b0;
        if (n >= 40) begin
            err_total++;
            end_sim;
        end
    endtask
    task t_pins;
        rdr(5'h00);
        chk(rd, 32'h0);
        for (int m = 0; m < 16; m++) begin
            wr(5'h00, 32'h20 | m);
            chk(mode, m);
            chk(so, m < 6);
            chk(io, m >= 6);
        end
        wr(5'h00, 32'h0);
        chk({so, io, en}, 3'h0);
        strb <= 4'he;
        wr(5'h00, 32'h25);
        strb <= 4'hf;
        chk(en, 1'b0);
        rdr(5'h10);
        chk(rsp, `SPSE_RESP_SLVERR);
        $display("pins test done");
    endtask
    task t_write_collision_flag;
        wr(5'h00, 32'h24);
        busy <= 1'b1;
        wr(5'h04, 32'h5a);
        chk(loads, 0);
        busy <= 1'b0;
        wr(5'h04, 32'h5a);
        chk(txb, 8'h5a);
        rdr(5'h00);
        chk({rd[7], loads[3:0]}, 5'h11);
        wr(5'h00, 32'h28);
        rdr(5'h00);
        chk(rd[7], 1'b0);
        idle <= 1'b0;
        wr(5'h04, 32'h01);
        rdr(5'h00);
        chk({rd[7], loads[3:0]}, 5'h11);
        idle <= 1'b1;
        wr(5'h04, 32'h02);
        chk(loads, 2);
        wr(5'h00, 32'h2b);
        idle <= 1'b0;
        wr(5'h04, 32'h03);
        idle <= 1'b1;
        rdr(5'h00);
        chk({rd[7], loads[3:0]}, 5'h12);
        wr(5'h00, 32'h26);
        busy <= 1'b1;
        wr(5'h04, 32'h04);
        busy <= 1'b0;
        rdr(5'h00);
        chk({rd[7], loads[3:0]}, 5'h12);
        $display("collision test done");
    endtask
    task t_ovf;
        wr(5'h00, 32'h24);
        wr(5'h08, 32'h3);
        peer.rx(8'ha1);
        peer.rx(8'hb2);
        rdr(5'h00);
        chk(rd[6], 1'b1);
        chk(irq, 1'b0);
        wr(5'h0c, 32'h2);
        chk(irq, 1'b1);
        rdr(5'h04);
        chk(rd, 32'ha1);
        peer.rx(8'hc3);
        rdr(5'h04);
        chk(rd, 32'hc3);
        rdr(5'h00);
        chk(rd[6], 1'b1);
        wr(5'h08, 32'h2);
        chk(irq, 1'b0);
        $display("overflow test done");
    endtask
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        {rst_n_i, awv, wv, brdy, arv, rrdy, busy} = 7'h0;
        {awa, ara, wd} = 42'h0;
        idle = 1'b1;
        strb = 4'hf;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_pins;
        t_write_collision_flag;
        t_ovf;
        end_sim;
    end
endmodule
